//--- src/prc_top.sv
// prc_top: run-time reconfiguration and phase shifting of a clock synthesizer.
// assumes: scan clock, scan and phase inputs are synchronous to mclk; mclk stands for the vco.
// Contract
// - each output and feedback counter may pick any of eight vco phase taps
// - one fine phase step is one tap, a vco period over eight
// - counter start is held off initial count minus one; count one means none
// - dynamic shift moves only taps, repeats freely, two scan clocks per step
// - pre-scale, feedback, c0-c4, charge pump and loop filter rewritable by scan
// - scan data enters on serial input under scan clock, at most 100 MHz
// - update strobe for one scan clock copies scan register into active bits
// - each counter adopts its new setting on its own counting clock
// - data enters on second rising scan edge after enable rises
// - done flag high during reconfiguration, falling edge means counters updated
// - each counter holds 8-bit high, 8-bit low, bypass and odd bits
// - bypass divides by one; otherwise divide by high plus low
// - odd clear: high for high count, low for low count, fall on rising edge
// - odd set: fall moves to falling edge, half a cycle from high to low
// - chain is 144 bits: seven 18-bit sections, then 9 pump and 9 filter
// - first bit is c4 low count lsb, last is loop filter msb
// - phase direction registered on rising scan edge, one up, zero down
`timescale 1ns/1ps
module prc_top (
	input wire logic mclk,
	input wire logic rst,
	input prc_pkg::prc_bus_req_t bus_req,
	output logic [prc_pkg::PRC_DW-1:0] rdata,
	input wire logic scan_clk,
	input wire logic scan_ena,
	input wire logic scan_data,
	input wire logic cfg_update,
	input prc_pkg::prc_phase_req_t phase_req,
	output logic scan_done,
	output logic [prc_pkg::PRC_NCNT-1:0][1:0] cnt_wave,
	output logic [prc_pkg::PRC_NCNT-1:0][prc_pkg::PRC_TAPW-1:0] tap_sel,
	output logic [prc_pkg::PRC_CPW-1:0] cp_set,
	output logic [prc_pkg::PRC_LFW-1:0] lf_set
);

	localparam int N = prc_pkg::PRC_NCNT;

	// ---------------------------------------------------------------
	// scan clock edge and scan chain
	// ---------------------------------------------------------------
	logic sclk_q_r;
	wire scan_rise = scan_clk && !sclk_q_r;
	logic [prc_pkg::PRC_CHAINW-1:0] chain_act;
	logic upd_pulse;

	always_ff @(posedge mclk or posedge rst) begin
		if (rst)
			sclk_q_r <= 1'b0;
		else
			sclk_q_r <= scan_clk;
	end

	prc_scan_chain #(
		.W(prc_pkg::PRC_CHAINW)
	) u_chain (
		.mclk(mclk),
		.rst(rst),
		.scan_rise(scan_rise),
		.scan_ena(scan_ena),
		.scan_data(scan_data),
		.cfg_update(cfg_update),
		.chain_act(chain_act),
		.upd_pulse(upd_pulse)
	);

	assign cp_set = chain_act[prc_pkg::PRC_CP_POS +: prc_pkg::PRC_CPW];
	assign lf_set = chain_act[prc_pkg::PRC_LF_POS +: prc_pkg::PRC_LFW];

	// ---------------------------------------------------------------
	// dynamic phase step
	// ---------------------------------------------------------------
	logic step_q_r;
	logic up_r;
	logic [2:0] sel_r;
	logic step_pend_r;
	logic [N-1:0][prc_pkg::PRC_TAPW-1:0] tap_r;
	wire step_edge = scan_rise && phase_req.step && !step_q_r;

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			step_q_r <= 1'b0;
			up_r <= 1'b0;
			sel_r <= 3'h0;
			step_pend_r <= 1'b0;
		end else if (scan_rise) begin
			step_q_r <= phase_req.step;
			up_r <= phase_req.up;
			sel_r <= phase_req.sel;
			step_pend_r <= step_edge;
		end
	end

	// ---------------------------------------------------------------
	// bus decode
	// ---------------------------------------------------------------
	logic [N-1:0][prc_pkg::PRC_CNTW-1:0] init_r;
	logic [N-1:0] start_r;
	logic boot_r;
	logic [N-1:0] pend_r;
	logic [N-1:0] ack;
	prc_pkg::prc_cnt_cfg_t [N-1:0] cfg_act;
	logic [prc_pkg::PRC_DW-1:0] rd_sel;
	logic [N-1:0] wr_ph;
	logic [N-1:0] rd_cfg;
	logic [N-1:0] rd_ph;

	wire wr_restart = bus_req.wr && (bus_req.addr == prc_pkg::PRC_A_RESTART);
	wire rd_status = (bus_req.addr == prc_pkg::PRC_A_STATUS);
	wire rd_loop = (bus_req.addr == prc_pkg::PRC_A_LOOP);

	// ---------------------------------------------------------------
	// per-counter slices
	// ---------------------------------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < N; gi++) begin : g_cnt
			localparam int SEC = prc_pkg::prc_sec_of(gi);
			localparam logic [7:0] A_CFG = prc_pkg::PRC_A_CFG0 + 8'(gi) * prc_pkg::PRC_A_STRIDE;
			localparam logic [7:0] A_PH = prc_pkg::PRC_A_PH0 + 8'(gi) * prc_pkg::PRC_A_STRIDE;
			localparam bit HAS_TAP = (gi <= prc_pkg::PRC_IDX_FB);
			localparam bit IS_C = (gi < prc_pkg::PRC_NSEC_C);
			localparam logic [2:0] MY_SEL = 3'(gi);
			wire prc_pkg::prc_cnt_cfg_t cfg_new = chain_act[SEC*prc_pkg::PRC_SECW +: prc_pkg::PRC_SECW];
			wire hit = (sel_r == MY_SEL) || (IS_C && sel_r == prc_pkg::PRC_SEL_ALLC);
			wire do_step = HAS_TAP && scan_rise && step_pend_r && hit;

			assign rd_cfg[gi] = (bus_req.addr == A_CFG);
			assign rd_ph[gi] = (bus_req.addr == A_PH);
			assign wr_ph[gi] = bus_req.wr && rd_ph[gi];
			assign tap_sel[gi] = tap_r[gi];

			always_ff @(posedge mclk or posedge rst) begin
				if (rst) begin
					tap_r[gi] <= '0;
					init_r[gi] <= prc_pkg::PRC_INIT_RST;
					start_r[gi] <= 1'b0;
					pend_r[gi] <= 1'b0;
				end else begin
					// one tap per step, wrapping through all eight phases
					if (do_step)
						tap_r[gi] <= up_r ? tap_r[gi] + 3'h1 : tap_r[gi] - 3'h1;
					if (wr_ph[gi])
						init_r[gi] <= bus_req.wdata[prc_pkg::PRC_CNTW-1:0];
					start_r[gi] <= boot_r || (wr_restart && bus_req.wdata[gi]);
					// a new update wins over an acknowledge in the same cycle
					if (upd_pulse)
						pend_r[gi] <= 1'b1;
					else if (ack[gi])
						pend_r[gi] <= 1'b0;
				end
			end

			prc_post_counter u_cnt (
				.mclk(mclk),
				.rst(rst),
				.cfg_new(cfg_new),
				.load_req(pend_r[gi]),
				.start(start_r[gi]),
				.start_cnt(init_r[gi]),
				.ack(ack[gi]),
				.cfg_act(cfg_act[gi]),
				.clk_wave(cnt_wave[gi])
			);
		end
	endgenerate

	// ---------------------------------------------------------------
	// read mux, done flag
	// ---------------------------------------------------------------
	always_comb begin
		rd_sel = '0;
		if (rd_status)
			rd_sel = {{(prc_pkg::PRC_DW-1){1'b0}}, scan_done};
		else if (rd_loop)
			rd_sel = {{(prc_pkg::PRC_DW-prc_pkg::PRC_CPW-prc_pkg::PRC_LFW){1'b0}}, lf_set, cp_set};
		else begin
			for (int i = 0; i < N; i++) begin
				if (rd_cfg[i])
					rd_sel = {{(prc_pkg::PRC_DW-prc_pkg::PRC_SECW){1'b0}}, cfg_act[i]};
				else if (rd_ph[i])
					rd_sel = {{(prc_pkg::PRC_DW-prc_pkg::PRC_CNTW-prc_pkg::PRC_TAPW){1'b0}}, tap_r[i], init_r[i]};
			end
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			boot_r <= 1'b1;
			rdata <= '0;
			scan_done <= 1'b0;
		end else begin
			boot_r <= 1'b0;
			rdata <= bus_req.rd ? rd_sel : '0;
			scan_done <= upd_pulse || (|(pend_r & ~ack));
		end
	end

endmodule : prc_top

//--- common/prc_pkg.sv
// prc_pkg: constants, types and register map of the pll run-time reconfiguration block.
// assumes: one clock (mclk, one vco period per edge), scan clock sampled as a plain input.
package prc_pkg;

	// ---------------------------------------------------------------
	// sizes
	// ---------------------------------------------------------------
	localparam int PRC_NCNT = 7;
	localparam int PRC_NTAP = 8;
	localparam int PRC_TAPW = 3;
	localparam int PRC_CNTW = 8;
	localparam int PRC_SECW = 18;
	localparam int PRC_NSEC_C = 5;
	localparam int PRC_CPW = 9;
	localparam int PRC_LFW = 9;
	localparam int PRC_CHAINW = 144;
	localparam int PRC_SCAN_MAX_MHZ = 100;

	// ---------------------------------------------------------------
	// chain layout, first bit shifted in lands at bit 0
	// ---------------------------------------------------------------
	localparam int PRC_CP_POS = 126;
	localparam int PRC_LF_POS = 135;
	localparam logic [PRC_CHAINW-1:0] PRC_CHAIN_RST = 144'h0;

	// counter index: 0..4 = c0..c4, 5 = feedback, 6 = pre-scale
	localparam int PRC_IDX_FB = 5;
	localparam logic [2:0] PRC_SEL_FB = 3'h5;
	localparam logic [2:0] PRC_SEL_ALLC = 3'h7;

	// ---------------------------------------------------------------
	// register map (byte addresses)
	// ---------------------------------------------------------------
	localparam int PRC_AW = 8;
	localparam int PRC_DW = 32;
	localparam logic [7:0] PRC_A_STATUS = 8'h00;
	localparam logic [7:0] PRC_A_LOOP = 8'h04;
	localparam logic [7:0] PRC_A_RESTART = 8'h08;
	localparam logic [7:0] PRC_A_CFG0 = 8'h20;
	localparam logic [7:0] PRC_A_PH0 = 8'h40;
	localparam logic [7:0] PRC_A_STRIDE = 8'h04;
	localparam int PRC_PH_TAP_POS = 8;
	localparam logic [7:0] PRC_INIT_RST = 8'h01;
	localparam logic [7:0] PRC_INIT_ONE = 8'h01;

	// ---------------------------------------------------------------
	// types
	// ---------------------------------------------------------------
	typedef struct packed {
		logic bypass;
		logic [PRC_CNTW-1:0] hi;
		logic odd;
		logic [PRC_CNTW-1:0] lo;
	} prc_cnt_cfg_t;

	typedef struct packed {
		logic [PRC_AW-1:0] addr;
		logic [PRC_DW-1:0] wdata;
		logic wr;
		logic rd;
	} prc_bus_req_t;

	typedef struct packed {
		logic step;
		logic up;
		logic [2:0] sel;
	} prc_phase_req_t;

	typedef enum logic {
		PRC_ST_WAIT,
		PRC_ST_RUN
	} prc_cnt_st_t;

	// chain section of counter i: c4..c0 first, then feedback, then pre-scale
	function automatic int prc_sec_of(input int i);
		return (i < PRC_NSEC_C) ? (PRC_NSEC_C - 1 - i) : i;
	endfunction : prc_sec_of

endpackage : prc_pkg

//--- src/prc_scan_chain.sv
// prc_scan_chain: serial scan register and its update copy.
// assumes: scan_rise marks one mclk cycle per rising scan clock edge.
`timescale 1ns/1ps
module prc_scan_chain #(
	parameter int W = prc_pkg::PRC_CHAINW
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic scan_rise,
	input wire logic scan_ena,
	input wire logic scan_data,
	input wire logic cfg_update,
	output logic [W-1:0] chain_act,
	output logic upd_pulse
);

	logic ena_q_r;
	logic upd_q_r;
	logic [W-1:0] shift_r;
	wire do_shift = scan_rise && scan_ena && ena_q_r;
	wire do_upd = scan_rise && cfg_update && !upd_q_r;

	// ---------------------------------------------------------------
	// shift and update
	// ---------------------------------------------------------------
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			ena_q_r <= 1'b0;
			upd_q_r <= 1'b0;
			shift_r <= prc_pkg::PRC_CHAIN_RST;
			chain_act <= prc_pkg::PRC_CHAIN_RST;
			upd_pulse <= 1'b0;
		end else begin
			upd_pulse <= do_upd;
			if (scan_rise) begin
				ena_q_r <= scan_ena;
				upd_q_r <= cfg_update;
			end
			if (do_shift)
				shift_r <= {scan_data, shift_r[W-1:1]};
			if (do_upd)
				chain_act <= shift_r;
		end
	end

endmodule : prc_scan_chain

//--- src/prc_post_counter.sv
// prc_post_counter: one divide counter with start delay, bypass and odd duty.
// assumes: each mclk edge is one vco period of the selected phase tap.
`timescale 1ns/1ps
module prc_post_counter (
	input wire logic mclk,
	input wire logic rst,
	input prc_pkg::prc_cnt_cfg_t cfg_new,
	input wire logic load_req,
	input wire logic start,
	input wire logic [prc_pkg::PRC_CNTW-1:0] start_cnt,
	output logic ack,
	output prc_pkg::prc_cnt_cfg_t cfg_act,
	output logic [1:0] clk_wave
);

	prc_pkg::prc_cnt_st_t st_r;
	prc_pkg::prc_cnt_st_t st_nxt;
	logic [prc_pkg::PRC_CNTW-1:0] dly_r;
	logic [prc_pkg::PRC_CNTW-1:0] dly_nxt;
	logic [prc_pkg::PRC_CNTW:0] pos_r;
	logic [prc_pkg::PRC_CNTW:0] pos_nxt;

	// ---------------------------------------------------------------
	// period and waveform
	// ---------------------------------------------------------------
	wire [prc_pkg::PRC_CNTW:0] sum = {1'b0, cfg_act.hi} + {1'b0, cfg_act.lo};
	wire [prc_pkg::PRC_CNTW:0] len = (cfg_act.bypass || sum == '0) ? 9'h001 : sum;
	wire run = (st_r == prc_pkg::PRC_ST_RUN);
	wire wrap = run && (pos_r == len - 9'h001);
	wire adopt = load_req && (!run || wrap);
	wire hi_lvl = (pos_r < {1'b0, cfg_act.hi});
	wire odd_cut = cfg_act.odd && (pos_r == {1'b0, cfg_act.hi} - 9'h001);
	wire [1:0] wave_nxt = !run ? 2'b00 : cfg_act.bypass ? 2'b10 : {hi_lvl, hi_lvl && !odd_cut};
	wire [prc_pkg::PRC_CNTW-1:0] start_dly = (start_cnt == '0) ? '0 : start_cnt - prc_pkg::PRC_INIT_ONE;

	// ---------------------------------------------------------------
	// start delay and counting
	// ---------------------------------------------------------------
	always_comb begin
		st_nxt = st_r;
		dly_nxt = dly_r;
		pos_nxt = pos_r;
		if (start) begin
			st_nxt = prc_pkg::PRC_ST_WAIT;
			dly_nxt = start_dly;
			pos_nxt = '0;
		end else begin
			case (st_r)
				prc_pkg::PRC_ST_WAIT: begin
					if (dly_r == '0)
						st_nxt = prc_pkg::PRC_ST_RUN;
					else
						dly_nxt = dly_r - 8'h01;
				end
				prc_pkg::PRC_ST_RUN: begin
					pos_nxt = wrap ? '0 : pos_r + 9'h001;
				end
				default: st_nxt = prc_pkg::PRC_ST_WAIT;
			endcase
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			st_r <= prc_pkg::PRC_ST_WAIT;
			dly_r <= '0;
			pos_r <= '0;
			cfg_act <= '0;
			ack <= 1'b0;
			clk_wave <= 2'b00;
		end else begin
			st_r <= st_nxt;
			dly_r <= dly_nxt;
			pos_r <= pos_nxt;
			clk_wave <= wave_nxt;
			ack <= adopt;
			if (adopt)
				cfg_act <= cfg_new;
		end
	end

endmodule : prc_post_counter

//--- bench/prc_checker.sv
// prc_checker: port assertions for the run-time reconfiguration block.
// assumes: bound to prc_top, one clock, reset active high.
`timescale 1ns/1ps
module prc_checker (
	input wire logic mclk,
	input wire logic rst,
	input prc_pkg::prc_bus_req_t bus_req,
	input wire logic [prc_pkg::PRC_DW-1:0] rdata,
	input wire logic scan_clk,
	input wire logic cfg_update,
	input prc_pkg::prc_phase_req_t phase_req,
	input wire logic scan_done,
	input wire logic [prc_pkg::PRC_NCNT-1:0][1:0] cnt_wave,
	input wire logic [prc_pkg::PRC_NCNT-1:0][prc_pkg::PRC_TAPW-1:0] tap_sel,
	input wire logic [prc_pkg::PRC_CPW-1:0] cp_set,
	input wire logic [prc_pkg::PRC_LFW-1:0] lf_set
);
	logic sc_r;
	logic upd_r;
	wire logic rise = scan_clk & ~sc_r;
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			sc_r <= 1'b0;
			upd_r <= 1'b0;
		end else begin
			sc_r <= scan_clk;
			upd_r <= rise ? cfg_update : upd_r;
		end
	end
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	a_rdata_read_slot: assert property (rdata != '0 |-> $past(bus_req.rd)) else $error("read data outside its slot");
	a_done_after_update: assert property ($rose(scan_done) |-> $past(cfg_update, 2) || $past(cfg_update, 3))
		else $error("done rose without update");
	a_done_prompt: assert property (rise && cfg_update && !upd_r |-> ##[1:3] scan_done)
		else $error("done missing after update");
	a_done_bounded: assert property ($rose(scan_done) |-> ##[1:1000] !scan_done)
		else $error("done never fell");
	a_bw_on_update: assert property ($changed({cp_set, lf_set}) |-> $past(cfg_update) || $past(cfg_update, 2))
		else $error("bandwidth bits moved without update");
	a_prescale_tap_fixed: assert property (tap_sel[6] == '0) else $error("pre-scale tap moved");
	for (genvar i = 0; i < prc_pkg::PRC_NCNT; i++) begin : g_cnt
		a_wave_legal: assert property (cnt_wave[i] != 2'b01) else $error("wave rose inside a cycle");
		a_tap_one_step: assert property ($changed(tap_sel[i]) |-> tap_sel[i] == $past(tap_sel[i]) + 3'h1
			|| tap_sel[i] == $past(tap_sel[i]) - 3'h1) else $error("tap moved more than one");
		a_tap_on_rise: assert property ($changed(tap_sel[i]) |-> $past(rise) || $past(rise, 2))
			else $error("tap moved off a scan rise");
		a_tap_needs_step: assert property ($changed(tap_sel[i]) |-> $past(phase_req.step)
			|| $past(phase_req.step, 2)) else $error("tap moved without step");
	end
endmodule : prc_checker
bind prc_top prc_checker chk (.mclk, .rst, .bus_req, .rdata, .scan_clk, .cfg_update, .phase_req, .scan_done,
	.cnt_wave, .tap_sel, .cp_set, .lf_set);

//--- bench/prc_ctrl_model.sv
// prc_ctrl_model: fabric controller that shifts the scan chain and steps phases.
// assumes: tasks are entered at a rising mclk edge; half sets the scan clock rate.
`timescale 1ns/1ps
module prc_ctrl_model (
	input wire logic mclk,
	output logic scan_clk,
	output logic scan_ena,
	output logic scan_data,
	output logic cfg_update,
	output prc_pkg::prc_phase_req_t phase_req
);
	int half = 2;
	initial begin
		scan_clk = 1'b0;
		scan_ena = 1'b0;
		scan_data = 1'b0;
		cfg_update = 1'b0;
		phase_req = '0;
	end
	// scan clock stands low outside frames, at most mclk/2
	task automatic tick();
		repeat (half) @(posedge mclk);
		scan_clk <= 1'b1;
		repeat (half) @(posedge mclk);
		scan_clk <= 1'b0;
	endtask : tick
	task automatic load(input logic [prc_pkg::PRC_CHAINW-1:0] chain);
		scan_ena <= 1'b1;
		tick();
		for (int i = 0; i < prc_pkg::PRC_CHAINW; i++) begin
			scan_data <= chain[i];
			tick();
		end
		scan_ena <= 1'b0;
		scan_data <= ~chain[prc_pkg::PRC_CHAINW-1];
		cfg_update <= 1'b1;
		tick();
		cfg_update <= 1'b0;
	endtask : load
	task automatic step(input logic up, input logic [2:0] sel);
		phase_req <= '{step: 1'b1, up: up, sel: sel};
		tick();
		tick();
		phase_req.step <= 1'b0;
		tick();
	endtask : step
endmodule : prc_ctrl_model

//--- bench/prc_tb_top.sv
// prc_tb_top: self-checking bench for prc_top.
// assumes: prc_checker is bound to the design; the controller model drives scan and phase ports.
`timescale 1ns/1ps
module prc_tb_top;
	logic mclk, rst, scan_clk, scan_ena, scan_data, cfg_update, scan_done;
	prc_pkg::prc_bus_req_t bus_req;
	prc_pkg::prc_phase_req_t phase_req;
	logic [prc_pkg::PRC_DW-1:0] rdata;
	logic [prc_pkg::PRC_NCNT-1:0][1:0] cnt_wave;
	logic [prc_pkg::PRC_NCNT-1:0][2:0] tap_sel, tap_exp;
	logic [prc_pkg::PRC_CPW-1:0] cp_set;
	logic [prc_pkg::PRC_LFW-1:0] lf_set;
	logic [prc_pkg::PRC_CHAINW-1:0] chain;
	logic [31:0] seed = 32'h8DA85A52;
	logic [31:0] s;
	int n_mismatch = 0;
	int checks = 0;
	int n1, n2;
	prc_top dut (.mclk, .rst, .bus_req, .rdata, .scan_clk, .scan_ena, .scan_data, .cfg_update, .phase_req,
		.scan_done, .cnt_wave, .tap_sel, .cp_set, .lf_set);
	prc_ctrl_model pm (.mclk, .scan_clk, .scan_ena, .scan_data, .cfg_update, .phase_req);
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd
	function automatic int sec(input int i);
		return (i < 5) ? 4 - i : i;
	endfunction : sec
	function automatic logic [1:0] wexp(input logic [17:0] c, input int p);
		if (c[17]) return 2'b10;
		if (p < c[16:9]) return (c[8] && p == c[16:9] - 1) ? 2'b10 : 2'b11;
		return 2'b00;
	endfunction : wexp
	task automatic conclude();
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : conclude
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge mclk);
		bus_req <= '0;
		@(posedge mclk);
	endtask : wr
	task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
		bus_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
		@(posedge mclk);
		bus_req <= '0;
		@(posedge mclk);
		chk($sformatf("rdata %h", a), e, rdata);
	endtask : rdchk
	task automatic wait_done();
		int n;
		n = 0;
		while (scan_done !== 1'b1 && n < 10) begin
			@(posedge mclk);
			n++;
		end
		chk("scan_done high", 32'h1, {31'h0, scan_done});
		if (scan_done !== 1'b1) conclude();
		while (scan_done !== 1'b0 && n < 3000) begin
			@(posedge mclk);
			n++;
		end
		chk("scan_done low", 32'h0, {31'h0, scan_done});
		if (scan_done !== 1'b0) conclude();
	endtask : wait_done
	task automatic chk_wave(input int i);
		logic [17:0] c;
		logic [1:0] pv;
		int n;
		c = chain[18*sec(i) +: 18];
		pv = 2'b11;
		n = 0;
		while (!c[17] && !(pv == 2'b00 && cnt_wave[i] != 2'b00) && n < 1200) begin
			pv = cnt_wave[i];
			@(posedge mclk);
			n++;
		end
		chk($sformatf("wave %0d wait", i), 32'h1, 32'(n < 1200));
		if (n >= 1200) conclude();
		for (int p = 0; p < 8; p++) begin
			chk($sformatf("wave %0d", i), {30'h0, wexp(c, p % (c[16:9] + c[7:0]))}, {30'h0, cnt_wave[i]});
			@(posedge mclk);
		end
	endtask : chk_wave
	task automatic coarse(input logic [7:0] c, output int n);
		logic [1:0] pv;
		wr(8'(prc_pkg::PRC_A_PH0 + 8), {24'h0, c});
		pv = 2'b00;
		n = 0;
		while (!(pv == 2'b11 && cnt_wave[2] == 2'b00) && n < 100) begin
			pv = cnt_wave[2];
			@(posedge mclk);
			n++;
		end
		chk("coarse edge wait", 32'h1, 32'(n < 100));
		if (n >= 100) conclude();
		bus_req <= '{addr: prc_pkg::PRC_A_RESTART, wdata: 32'h4, wr: 1'b1, rd: 1'b0};
		n = 0;
		@(posedge mclk);
		bus_req <= '0;
		while (cnt_wave[2] !== 2'b11 && n < 100) begin
			@(posedge mclk);
			n++;
		end
		chk("coarse start wait", 32'h1, 32'(n < 100));
		if (n >= 100) conclude();
	endtask : coarse
	// ---------------------------------------------------------------
	// main sequence
	// ---------------------------------------------------------------
	initial begin
		rst = 1'b1;
		bus_req = '0;
		tap_exp = '0;
		repeat (12) @(posedge mclk);
		rst <= 1'b0;
		@(posedge mclk);
		rdchk(prc_pkg::PRC_A_STATUS, 32'h0);
		rdchk(prc_pkg::PRC_A_LOOP, 32'h0);
		rdchk(8'hFC, 32'h0);
		for (int i = 0; i < 7; i++) rdchk(8'(prc_pkg::PRC_A_PH0 + 4 * i), 32'h1);
		for (int it = 0; it < 3; it++) begin
			pm.half = int'(rnd() % 3) + 1;
			chain = 144'({rnd(), rnd(), rnd(), rnd(), rnd()});
			chain[4*18+17] = 1'b1;
			chain[3*18 +: 18] = {1'b0, 8'h02, 1'b1, 8'h01};
			chain[2*18 +: 18] = {1'b0, 8'h02, 1'b0, 8'h08};
			pm.load(chain);
			wait_done();
			for (int i = 0; i < 7; i++) rdchk(8'(prc_pkg::PRC_A_CFG0 + 4 * i), {14'h0, chain[18*sec(i) +: 18]});
			rdchk(prc_pkg::PRC_A_LOOP, {14'h0, chain[143:126]});
			chk("cp_lf", {14'h0, chain[143:126]}, {14'h0, lf_set, cp_set});
			chk("taps kept", 32'(tap_exp), 32'(tap_sel));
			chk_wave(0);
			chk_wave(1);
			chk_wave(2);
			for (int k = 0; k < 8; k++) begin
				s = rnd();
				pm.step(s[0], 3'(k));
				for (int j = 0; j < 6; j++) begin
					if (j == k || (k == 7 && j < 5)) tap_exp[j] = s[0] ? tap_exp[j] + 3'h1 : tap_exp[j] - 3'h1;
				end
				chk("taps", 32'(tap_exp), 32'(tap_sel));
			end
		end
		coarse(8'h02, n1);
		coarse(8'h06, n2);
		chk("coarse delay", 32'h4, 32'(n2 - n1));
		rdchk(8'(prc_pkg::PRC_A_PH0 + 8), {21'h0, tap_exp[2], 8'h06});
		// pll reset after the frequency changes; the whole block returns to its reset state
		rst <= 1'b1;
		repeat (3) @(posedge mclk);
		rst <= 1'b0;
		@(posedge mclk);
		tap_exp = '0;
		rdchk(prc_pkg::PRC_A_STATUS, 32'h0);
		rdchk(prc_pkg::PRC_A_LOOP, 32'h0);
		rdchk(8'(prc_pkg::PRC_A_PH0 + 8), 32'h1);
		chk("taps after reset", 32'(tap_exp), 32'(tap_sel));
		conclude();
	end
endmodule : prc_tb_top
